// ===== hw/aior_router.v
// audio io router: return, output pair conditioning and host/digital feed select
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "aior_map.vh"
module aior_router (
    input wire aclk, // 20 MHz clock
    input wire aresetn, // synchronous reset, active low
    input wire [3:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte enables
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output wire [1:0] s_axi_bresp, // write response
    output wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [3:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output wire [31:0] s_axi_rdata, // read data
    output wire [1:0] s_axi_rresp, // read response
    output wire s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire sample_valid, // one-cycle strobe per sample frame
    input wire [47:0] grid_mix, // output 1 mix after global eq, {r,l}
    input wire [47:0] grid_mix_pre_eq, // output 1 mix before global eq, {r,l}
    input wire [47:0] send_return_block, // loop block mixer output, {r,l}
    input wire [47:0] return_in, // return input pair, {r,l}
    input wire [47:0] main_in, // main grid input pair, {r,l}
    input wire usb_high_speed, // host runs high-speed usb
    output wire [47:0] return_out, // conditioned return pair
    output wire [47:0] dac_a, // output 1 converter samples
    output wire [47:0] dac_b, // output 2 converter samples
    output wire [47:0] digital_out, // digital interface samples
    output wire [47:0] usb_main, // primary usb channel pair
    output wire [47:0] usb_dry, // second usb pair, dry main input at high speed, else zero
    output wire out_valid, // one-cycle strobe, outputs updated
    output wire [4:0] pad_a_db, // output 1 analog pad in dB
    output wire [4:0] pad_b_db, // output 2 analog pad in dB
    output wire fmt_consumer_en, // consumer digital format active
    output wire fmt_pro_en, // professional digital format active
    output wire pair_a_overload_indicator, // output 1 clip lamp
    output wire irq // level interrupt
);
    reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    reg [1:0] bresp_ff, rresp_ff;
    reg [31:0] rdata_ff;
    reg [3:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg [`AIOR_CTRL_BITS-1:0] ctrl_ff;
    reg [`AIOR_BOOST_BITS-1:0] boost_ff;
    reg [1:0] status_ff, mask_ff, nxt_status;
    reg irq_ff;
    reg [47:0] return_out_ff, dac_a_ff, dac_b_ff, digital_ff, usb_main_ff, usb_dry_ff;
    reg out_valid_ff, overload_ff;
    reg [31:0] rd_mux;
    reg [1:0] rd_resp;
    reg [1:0] w1c;
    // a write runs once both halves are held and no answer is pending
    wire do_write = !awready_ff && !wready_ff && !bvalid_ff;
    // boost gain table, Q4.12, one entry per dB, clamped at the ceiling
    function [16:0] gain_of;
        input [4:0] db;
        begin
            case ((db > `AIOR_BOOST_MAX) ? `AIOR_BOOST_MAX : db)
                5'h00: gain_of = 17'h01000;
                5'h01: gain_of = 17'h011f4;
                5'h02: gain_of = 17'h01425;
                5'h03: gain_of = 17'h0169a;
                5'h04: gain_of = 17'h0195c;
                5'h05: gain_of = 17'h01c74;
                5'h06: gain_of = 17'h01fed;
                5'h07: gain_of = 17'h023d2;
                5'h08: gain_of = 17'h02831;
                5'h09: gain_of = 17'h02d18;
                5'h0a: gain_of = 17'h03299;
                5'h0b: gain_of = 17'h038c5;
                5'h0c: gain_of = 17'h03fb2;
                5'h0d: gain_of = 17'h04778;
                5'h0e: gain_of = 17'h05031;
                5'h0f: gain_of = 17'h059fa;
                5'h10: gain_of = 17'h064f4;
                5'h11: gain_of = 17'h07145;
                default: gain_of = 17'h07f18;
            endcase
        end
    endfunction
    // saturating add, bit 24 flags overflow
    function [24:0] sat_add;
        input [23:0] a;
        input [23:0] b;
        reg [24:0] s;
        begin
            s = {a[23], a} + {b[23], b};
            sat_add = (s[24] != s[23]) ? {1'b1, s[24], {23{~s[24]}}} : {1'b0, s[23:0]};
        end
    endfunction
    // saturating boost, bit 24 flags overflow
    function [24:0] sat_boost;
        input [23:0] x;
        input [4:0] db;
        reg signed [40:0] p;
        begin
            p = $signed(x) * $signed(gain_of(db));
            sat_boost = (!(&p[40:35]) && (|p[40:35])) ? {1'b1, p[40], {23{~p[40]}}} :
                {1'b0, p[35:12]};
        end
    endfunction
    // saturating negate when enabled, bit 24 flags overflow
    function [24:0] sat_neg;
        input [23:0] x;
        input en;
        reg [23:0] n;
        begin
            n = ~x + 24'h000001;
            sat_neg = !en ? {1'b0, x} :
                (x == 24'h800000) ? {1'b1, 24'h7fffff} : {1'b0, n};
        end
    endfunction
    // channel modes ahead of boost
    wire [24:0] ret_sum = sat_add(return_in[23:0], return_in[47:24]);
    wire [24:0] a_sum = sat_add(grid_mix[23:0], grid_mix[47:24]);
    // mirrored feed taps the mix ahead of output 1 global eq
    wire [47:0] b_src = ctrl_ff[`AIOR_MIRROR] ? grid_mix_pre_eq : send_return_block;
    wire [24:0] b_sum = sat_add(b_src[23:0], b_src[47:24]);
    // sum overflow only counts while the pair is in sum mode
    wire a_sum_ovf = (ctrl_ff[`AIOR_A_MODE] == `AIOR_A_SUM) && a_sum[24];
    wire b_sum_ovf = (ctrl_ff[`AIOR_B_MODE] == `AIOR_B_SUM) && b_sum[24];
    reg [47:0] ret_m, a_m, b_m;
    // mode selection per pair
    always @* begin
        case (ctrl_ff[`AIOR_RET_MODE])
            `AIOR_RET_LEFT: ret_m = {return_in[23:0], return_in[23:0]};
            `AIOR_RET_SUM: ret_m = {ret_sum[23:0], ret_sum[23:0]};
            default: ret_m = return_in;
        endcase
        case (ctrl_ff[`AIOR_A_MODE])
            `AIOR_A_SUM: a_m = {a_sum[23:0], a_sum[23:0]};
            `AIOR_A_COPY: a_m = {grid_mix[23:0], grid_mix[23:0]};
            default: a_m = grid_mix;
        endcase
        case (ctrl_ff[`AIOR_B_MODE])
            `AIOR_B_SUM: b_m = {b_sum[23:0], b_sum[23:0]};
            `AIOR_B_STEREO: b_m = b_src;
            default: b_m = {b_src[23:0], b_src[23:0]};
        endcase
    end
    // per channel boost, inversion and dry input boost
    wire [47:0] a_fin, b_fin, in_fin;
    wire [1:0] a_ovf, b_ovf;
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            wire [24:0] a_bst = sat_boost(a_m[i*24 +: 24], boost_ff[`AIOR_BOOST_A]);
            wire [24:0] a_inv = sat_neg(a_bst[23:0], ctrl_ff[`AIOR_A_INV]);
            wire [24:0] b_bst = sat_boost(b_m[i*24 +: 24], boost_ff[`AIOR_BOOST_B]);
            wire [24:0] b_inv = sat_neg(b_bst[23:0], ctrl_ff[`AIOR_B_INV]);
            wire [24:0] i_bst = sat_boost(main_in[i*24 +: 24], boost_ff[`AIOR_BOOST_A]);
            assign a_fin[i*24 +: 24] = a_inv[23:0];
            assign b_fin[i*24 +: 24] = b_inv[23:0];
            assign in_fin[i*24 +: 24] = i_bst[23:0];
            assign a_ovf[i] = a_bst[24] | a_inv[24];
            assign b_ovf[i] = b_bst[24] | b_inv[24];
        end
    endgenerate
    wire clip_a = (|a_ovf) | a_sum_ovf;
    wire clip_b = (|b_ovf) | b_sum_ovf;
    // host and digital feed mux
    reg [47:0] feed;
    always @* begin
        case (ctrl_ff[`AIOR_FEED])
            `AIOR_FEED_B: feed = b_fin;
            `AIOR_FEED_IN: feed = in_fin;
            default: feed = a_fin;
        endcase
    end
    // sample outputs, registered once per frame
    always @(posedge aclk) begin
        if (!aresetn) begin
            return_out_ff <= 48'h000000000000;
            dac_a_ff <= 48'h000000000000;
            dac_b_ff <= 48'h000000000000;
            digital_ff <= 48'h000000000000;
            usb_main_ff <= 48'h000000000000;
            usb_dry_ff <= 48'h000000000000;
            out_valid_ff <= 1'b0;
            overload_ff <= 1'b0;
        end else begin
            out_valid_ff <= sample_valid;
            if (sample_valid) begin
                return_out_ff <= ret_m;
                dac_a_ff <= a_fin;
                dac_b_ff <= b_fin;
                digital_ff <= feed;
                usb_main_ff <= feed;
                usb_dry_ff <= usb_high_speed ? main_in : 48'h000000000000;
                overload_ff <= clip_a;
            end
        end
    end
    // write address and data capture, then write and respond
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= `AIOR_RESP_OKAY;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_ff) begin
                awready_ff <= 1'b0;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (awaddr_ff[1:0] == 2'h0) ? `AIOR_RESP_OKAY : `AIOR_RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end
    // one-to-clear mask from a status write
    always @* begin
        w1c = 2'h0;
        if (do_write && awaddr_ff == `AIOR_STATUS_OFF && wstrb_ff[0])
            w1c = wdata_ff[1:0];
        nxt_status = (status_ff & ~w1c) | {sample_valid & clip_b, sample_valid & clip_a};
    end
    // control registers take effect on the write itself
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `AIOR_CTRL_RST;
            boost_ff <= `AIOR_BOOST_RST;
            mask_ff <= `AIOR_IRQ_RST;
            status_ff <= `AIOR_IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            if (do_write) begin
                if (awaddr_ff == `AIOR_CTRL_OFF) begin
                    if (wstrb_ff[0])
                        ctrl_ff[7:0] <= wdata_ff[7:0];
                    if (wstrb_ff[1])
                        ctrl_ff[11:8] <= wdata_ff[11:8];
                end
                if (awaddr_ff == `AIOR_BOOST_OFF) begin
                    if (wstrb_ff[0])
                        boost_ff[4:0] <= wdata_ff[4:0];
                    if (wstrb_ff[1])
                        boost_ff[12:8] <= wdata_ff[12:8];
                end
                if (awaddr_ff == `AIOR_MASK_OFF && wstrb_ff[0])
                    mask_ff <= wdata_ff[1:0];
            end
            status_ff <= nxt_status; // set beats clear
            irq_ff <= |(nxt_status & mask_ff);
        end
    end
    // read decode
    always @* begin
        rd_mux = 32'h00000000;
        rd_resp = `AIOR_RESP_OKAY;
        case (s_axi_araddr)
            `AIOR_CTRL_OFF: rd_mux = {20'h00000, ctrl_ff};
            `AIOR_BOOST_OFF: rd_mux = {19'h00000, boost_ff};
            `AIOR_STATUS_OFF: rd_mux = {30'h00000000, status_ff};
            `AIOR_MASK_OFF: rd_mux = {30'h00000000, mask_ff};
            default: rd_resp = `AIOR_RESP_SLVERR;
        endcase
    end
    // read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `AIOR_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_resp;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign return_out = return_out_ff;
    assign dac_a = dac_a_ff;
    assign dac_b = dac_b_ff;
    assign digital_out = digital_ff;
    assign usb_main = usb_main_ff;
    assign usb_dry = usb_dry_ff;
    assign out_valid = out_valid_ff;
    // pads track the boost fields directly
    assign pad_a_db = boost_ff[`AIOR_BOOST_A];
    assign pad_b_db = boost_ff[`AIOR_BOOST_B];
    assign fmt_consumer_en = ~ctrl_ff[`AIOR_FMT];
    assign fmt_pro_en = ctrl_ff[`AIOR_FMT];
    assign pair_a_overload_indicator = overload_ff;
    assign irq = irq_ff;
endmodule // aior_router

// ===== shared/aior_map.vh
// register map, field positions, reset values and codes of the audio io router
`ifndef AIOR_MAP_VH
`define AIOR_MAP_VH

// sample width
`define AIOR_SW 24
// gain fraction bits of the boost table
`define AIOR_GFRAC 12
// boost ceiling in dB
`define AIOR_BOOST_MAX 5'h12

// register byte offsets
`define AIOR_CTRL_OFF 4'h0
`define AIOR_BOOST_OFF 4'h4
`define AIOR_STATUS_OFF 4'h8
`define AIOR_MASK_OFF 4'hc

// control register fields
`define AIOR_RET_MODE 1:0
`define AIOR_A_MODE 3:2
`define AIOR_B_MODE 5:4
`define AIOR_A_INV 6
`define AIOR_B_INV 7
`define AIOR_MIRROR 8
`define AIOR_FMT 9
`define AIOR_FEED 11:10
`define AIOR_CTRL_BITS 12
`define AIOR_CTRL_RST 12'h000

// boost register fields
`define AIOR_BOOST_A 4:0
`define AIOR_BOOST_B 12:8
`define AIOR_BOOST_BITS 13
`define AIOR_BOOST_RST 13'h0000

// status and mask fields
`define AIOR_CLIP_A 0
`define AIOR_CLIP_B 1
`define AIOR_IRQ_RST 2'h0

// return input modes
`define AIOR_RET_STEREO 2'h0
`define AIOR_RET_LEFT 2'h1
`define AIOR_RET_SUM 2'h2

// output 1 modes
`define AIOR_A_STEREO 2'h0
`define AIOR_A_SUM 2'h1
`define AIOR_A_COPY 2'h2

// output 2 modes
`define AIOR_B_LEFT 2'h0
`define AIOR_B_SUM 2'h1
`define AIOR_B_STEREO 2'h2

// host and digital feed sources
`define AIOR_FEED_A 2'h0
`define AIOR_FEED_B 2'h1
`define AIOR_FEED_IN 2'h2

// axi responses
`define AIOR_RESP_OKAY 2'h0
`define AIOR_RESP_SLVERR 2'h2

`endif

// ===== testbench/aior_router_sva.sv
// port checker of the audio io router
`timescale 1ns/1ps
module aior_router_sva (
    input wire aclk, // clock
    input wire aresetn, // sync reset, active low
    input wire s_axi_awvalid, // write address valid
    input wire s_axi_awready, // write address ready
    input wire s_axi_wvalid, // write data valid
    input wire s_axi_wready, // write data ready
    input wire s_axi_bvalid, // write response valid
    input wire sample_valid, // frame strobe
    input wire [47:0] main_in, // main input pair
    input wire usb_high_speed, // host speed
    input wire [47:0] dac_a, // output 1 samples
    input wire [47:0] usb_main, // primary usb pair
    input wire [47:0] usb_dry, // dry usb pair
    input wire out_valid, // output strobe
    input wire [4:0] pad_a_db, // output 1 pad
    input wire [4:0] pad_b_db, // output 2 pad
    input wire fmt_consumer_en, // consumer format
    input wire fmt_pro_en, // professional format
    input wire pair_a_overload_indicator // clip lamp
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
a_fmt_one_hot: assert property (fmt_consumer_en != fmt_pro_en)
    else $error("digital format enables not exclusive");
a_frame_latency: assert property (sample_valid |=> out_valid)
    else $error("no output strobe after frame");
a_dry_pair: assert property (sample_valid |=>
    usb_dry == ($past(usb_high_speed) ? $past(main_in) : 48'h0))
    else $error("dry usb pair wrong");
a_hold_out: assert property (!sample_valid |=> $stable(dac_a) && $stable(usb_main))
    else $error("outputs moved without frame");
a_lamp_frame: assert property ($changed(pair_a_overload_indicator) |-> $past(sample_valid))
    else $error("clip lamp moved without frame");
a_pad_write: assert property ($changed(pad_a_db) || $changed(pad_b_db) |-> $rose(s_axi_bvalid))
    else $error("pad moved without write");
a_fmt_write: assert property ($changed(fmt_pro_en) |-> $rose(s_axi_bvalid))
    else $error("format moved without write");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
endmodule // aior_router_sva

bind aior_router aior_router_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .sample_valid, .main_in, .usb_high_speed,
    .dac_a, .usb_main, .usb_dry, .out_valid, .pad_a_db, .pad_b_db, .fmt_consumer_en,
    .fmt_pro_en, .pair_a_overload_indicator);

// ===== testbench/aior_host_model.sv
// far-side usb host model: reports its link speed
`timescale 1ns/1ps
module aior_host_model (
    input wire aclk, // clock
    input wire hs_req, // bench asks for a high-speed host
    output reg usb_high_speed // host speed level
);
// speed is known before the first edge, then follows the request
initial begin
    usb_high_speed = 1'b0;
end
always @(posedge aclk) begin
    usb_high_speed <= hs_req;
end
endmodule // aior_host_model

// ===== testbench/aior_router_test.sv
// self-checking bench of the audio io router
`timescale 1ns/1ps
`include "aior_map.vh"
module aior_router_test;
reg aclk = 1'b0, aresetn = 1'b0, hs_req = 1'b0, sample_valid = 1'b0;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
reg [31:0] s_axi_wdata = 32'h0;
reg [47:0] grid_mix = 48'h0, grid_mix_pre_eq = 48'h0, send_return_block = 48'h0;
reg [47:0] return_in = 48'h0, main_in = 48'h0;
reg [11:0] c;
reg [12:0] b;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, out_valid;
wire usb_high_speed, fmt_consumer_en, fmt_pro_en, pair_a_overload_indicator, irq;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [47:0] return_out, dac_a, dac_b, digital_out, usb_main, usb_dry;
wire [4:0] pad_a_db, pad_b_db;
integer error_cnt = 0, checks = 0, seed = 32'h86d4c5f6, cyc = 0, i;
aior_router dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sample_valid, .grid_mix, .grid_mix_pre_eq,
    .send_return_block, .return_in, .main_in, .usb_high_speed, .return_out, .dac_a, .dac_b,
    .digital_out, .usb_main, .usb_dry, .out_valid, .pad_a_db, .pad_b_db, .fmt_consumer_en,
    .fmt_pro_en, .pair_a_overload_indicator, .irq);
aior_host_model host (.aclk, .hs_req, .usb_high_speed);
// clock and hang guard
always #25 aclk = ~aclk;
always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
        error_cnt = error_cnt + 1;
        final_report;
    end
end
task final_report;
begin
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
end
endtask
task chk(input [63:0] nm, input [47:0] e, input [47:0] g);
begin
    checks = checks + 1;
    if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
    end
end
endtask
// bus master: address and data together, response awaited
task wr(input [3:0] a, input [31:0] d, input [1:0] er);
reg done;
begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
            chk("bresp", er, s_axi_bresp);
            s_axi_bready <= 1'b0;
            done = 1'b1;
        end
    end
    @(posedge aclk);
end
endtask
task rd(input [3:0] a, input [31:0] ed, input [1:0] er);
reg done;
begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
            chk("rdata", ed, s_axi_rdata);
            chk("rresp", er, s_axi_rresp);
            s_axi_rready <= 1'b0;
            done = 1'b1;
        end
    end
    @(posedge aclk);
end
endtask
// saturation to 24 bits, clip flag on top
function [24:0] sat(input signed [47:0] v);
    sat = (v > 48'sh7fffff) ? {1'b1, 24'h7fffff} :
        (v < -48'sh800000) ? {1'b1, 24'h800000} : {1'b0, v[23:0]};
endfunction
function [24:0] bst(input [23:0] x, input [4:0] db);
    integer g;
    reg signed [47:0] p;
    begin
        g = $rtoi(4096.0 * (10.0 ** (((db > 18) ? 18 : db) / 20.0)) + 0.5);
        p = $signed(x) * g;
        bst = sat(p >>> 12);
    end
endfunction
// mode 0 stereo, 1 sum on both, 2 left on both; then boost, then invert
function [48:0] proc(input [47:0] s, input [1:0] m, input [4:0] db, input inv);
    reg [24:0] l, r;
    reg k;
    begin
        l = {1'b0, s[23:0]};
        r = {1'b0, s[47:24]};
        if (m == 2'd1) l = sat({{24{s[23]}}, s[23:0]} + {{24{s[47]}}, s[47:24]});
        if (m != 2'd0) r = l;
        k = l[24];
        l = bst(l[23:0], db);
        r = bst(r[23:0], db);
        k = k | l[24] | r[24];
        if (inv) l = sat(-{{24{l[23]}}, l[23:0]});
        if (inv) r = sat(-{{24{r[23]}}, r[23:0]});
        proc = {k | l[24] | r[24], r[23:0], l[23:0]};
    end
endfunction
function [47:0] r48(input sm);
    reg [31:0] x, y;
    begin
        x = $random(seed);
        y = $random(seed);
        r48 = sm ? {{6{x[23]}}, x[23:6], {6{y[23]}}, y[23:6]} : {x[23:0], y[23:0]};
    end
endfunction
// one frame in, then every sample output compared
task frame_check;
reg [48:0] ea, eb, ef, er;
reg [1:0] ma, mb, mr;
begin
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
    #1;
    ma = (c[`AIOR_A_MODE] == 2'd3) ? 2'd0 : c[`AIOR_A_MODE];
    mb = (c[`AIOR_B_MODE] == `AIOR_B_STEREO) ? 2'd0 : (c[`AIOR_B_MODE] == `AIOR_B_SUM) ? 2'd1 : 2'd2;
    mr = (c[`AIOR_RET_MODE] == `AIOR_RET_LEFT) ? 2'd2 : (c[`AIOR_RET_MODE] == `AIOR_RET_SUM) ? 2'd1 : 2'd0;
    ea = proc(grid_mix, ma, b[`AIOR_BOOST_A], c[`AIOR_A_INV]);
    eb = proc(c[`AIOR_MIRROR] ? grid_mix_pre_eq : send_return_block, mb, b[`AIOR_BOOST_B],
        c[`AIOR_B_INV]);
    ef = proc(main_in, 2'd0, b[`AIOR_BOOST_A], 1'b0);
    ef = (c[`AIOR_FEED] == `AIOR_FEED_IN) ? ef : (c[`AIOR_FEED] == `AIOR_FEED_B) ? eb : ea;
    er = proc(return_in, mr, 5'h0, 1'b0);
    chk("ret", er[47:0], return_out);
    chk("dac_a", ea[47:0], dac_a);
    chk("dac_b", eb[47:0], dac_b);
    chk("digital", ef[47:0], digital_out);
    chk("usb", ef[47:0], usb_main);
    chk("dry", hs_req ? main_in : 48'h0, usb_dry);
    chk("lamp", {47'h0, ea[48]}, {47'h0, pair_a_overload_indicator});
    chk("strobe", 48'h1, {47'h0, out_valid});
    chk("pads", {b[12:8], b[4:0]}, {pad_b_db, pad_a_db});
    chk("fmt", {c[9], ~c[9]}, {fmt_pro_en, fmt_consumer_en});
    @(posedge aclk);
end
endtask
// main sequence
initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`AIOR_CTRL_OFF, 32'h0, `AIOR_RESP_OKAY);
    rd(`AIOR_BOOST_OFF, 32'h0, `AIOR_RESP_OKAY);
    rd(`AIOR_STATUS_OFF, 32'h0, `AIOR_RESP_OKAY);
    rd(`AIOR_MASK_OFF, 32'h0, `AIOR_RESP_OKAY);
    rd(4'h2, 32'h0, `AIOR_RESP_SLVERR);
    wr(4'h6, 32'h1f1f, `AIOR_RESP_SLVERR);
    rd(`AIOR_BOOST_OFF, 32'h0, `AIOR_RESP_OKAY);
    $display("test reset and access done");
    for (i = 0; i < 64; i = i + 1) begin
        c = $random(seed);
        b = $random(seed) & 32'h1f1f;
        hs_req <= $random(seed);
        wr(`AIOR_CTRL_OFF, {20'h0, c}, `AIOR_RESP_OKAY);
        wr(`AIOR_BOOST_OFF, {19'h0, b}, `AIOR_RESP_OKAY);
        rd(`AIOR_CTRL_OFF, {20'h0, c}, `AIOR_RESP_OKAY);
        grid_mix <= (i % 4 == 0) ? {24'h800000, 24'h7fffff} : r48(i[0]);
        grid_mix_pre_eq <= r48(i[0]);
        send_return_block <= r48(i[1]);
        return_in <= r48(i[0]);
        main_in <= r48(i[1]);
        frame_check;
    end
    $display("test random frames done");
    wr(`AIOR_STATUS_OFF, 32'h3, `AIOR_RESP_OKAY);
    wr(`AIOR_MASK_OFF, 32'h1, `AIOR_RESP_OKAY);
    c = 12'h000;
    b = 13'h0012;
    wr(`AIOR_CTRL_OFF, 32'h0, `AIOR_RESP_OKAY);
    wr(`AIOR_BOOST_OFF, 32'h12, `AIOR_RESP_OKAY);
    grid_mix <= {24'h7fffff, 24'h7fffff};
    send_return_block <= 48'h0;
    frame_check;
    #1;
    chk("irq", 48'h1, {47'h0, irq});
    @(posedge aclk);
    rd(`AIOR_STATUS_OFF, 32'h1, `AIOR_RESP_OKAY);
    wr(`AIOR_MASK_OFF, 32'h0, `AIOR_RESP_OKAY);
    #1;
    chk("irq", 48'h0, {47'h0, irq});
    @(posedge aclk);
    wr(`AIOR_STATUS_OFF, 32'h1, `AIOR_RESP_OKAY);
    rd(`AIOR_STATUS_OFF, 32'h0, `AIOR_RESP_OKAY);
    $display("test interrupt done");
    final_report;
end
endmodule // aior_router_test
